// File: src/psc_pkg.sv
package psc_pkg;

	// ==========================================================
	// Management register numbers
	localparam logic [4:0]  REG_BASIC_CONTROL   = 5'h00;
	localparam logic [4:0]  REG_ADVERTISE       = 5'h04;
	localparam logic [4:0]  REG_GIGABIT_CONTROL = 5'h09;
	localparam logic [4:0]  REG_CROSSOVER_CFG   = 5'h10;
	localparam logic [4:0]  REG_IRQ_MASK        = 5'h18;
	localparam logic [4:0]  REG_IRQ_STATUS      = 5'h19;

	// ==========================================================
	// Field positions
	localparam int BC_SPEED_LSB     = 13;
	localparam int BC_AN_ENABLE     = 12;
	localparam int BC_DUPLEX        = 8;
	localparam int BC_SPEED_MSB     = 6;
	localparam int ADV_10HD         = 5;
	localparam int ADV_10FD         = 6;
	localparam int ADV_100HD        = 7;
	localparam int ADV_100FD        = 8;
	localparam int ADV_PAUSE        = 10;
	localparam int ADV_ASYM_PAUSE   = 11;
	localparam int GC_MANUAL        = 12;
	localparam int GC_MANUAL_MASTER = 11;
	localparam int GC_PORT_PREF     = 10;
	localparam int GC_1000FD        = 9;
	localparam int GC_1000HD        = 8;
	localparam int XC_AUTO          = 0;
	localparam int XC_FORCE         = 1;

	// ==========================================================
	// Reset values and writable bits
	localparam logic [15:0] BASIC_CONTROL_RST = 16'h1140;
	localparam logic [15:0] ADVERTISE_RST     = 16'h01E1;
	localparam logic [15:0] GIGABIT_CTRL_RST  = 16'h0300;
	localparam logic [15:0] CROSSOVER_RST     = 16'h0001;
	localparam logic [15:0] ADV_SELECTOR      = 16'h0001;
	localparam logic [15:0] BC_WMASK          = 16'h3140;
	localparam logic [15:0] ADV_WMASK         = 16'h0DE0;
	localparam logic [15:0] GC_WMASK          = 16'h1F00;
	localparam logic [15:0] XC_WMASK          = 16'h0003;
	localparam logic [4:0]  STATION_ADDR_RST  = 5'h01;

	// ==========================================================
	// Interrupt sources
	localparam int NUM_IRQ         = 9;
	localparam int IRQ_AN_CHANGE   = 0;
	localparam int IRQ_PAGE_RX     = 1;
	localparam int IRQ_FIFO_ERR    = 2;
	localparam int IRQ_LINK_CHANGE = 3;
	localparam int IRQ_CRC_ERR     = 4;
	localparam int IRQ_CNT_FULL    = 5;
	localparam int IRQ_RX_STATUS   = 6;
	localparam int IRQ_DOWNSHIFT   = 7;
	localparam int IRQ_SYNC_LOST   = 8;

	// ==========================================================
	// Strap vector layout; the low LED_SHARED bits share LED pins
	localparam int STRAP_SP1000    = 0;
	localparam int STRAP_SP100     = 1;
	localparam int STRAP_SP10      = 2;
	localparam int STRAP_DUPLEX    = 3;
	localparam int STRAP_ROLE      = 4;
	localparam int STRAP_PAUSE     = 5;
	localparam int STRAP_XAUTO     = 6;
	localparam int STRAP_XFORCE    = 7;
	localparam int STRAP_ADDR_LSB  = 8;
	localparam int STRAP_WIDTH     = 13;
	localparam int LED_SHARED      = 3;

	// ==========================================================
	// Technologies and speed codes
	localparam int TECH_10HD   = 0;
	localparam int TECH_10FD   = 1;
	localparam int TECH_100HD  = 2;
	localparam int TECH_100FD  = 3;
	localparam int TECH_1000HD = 4;
	localparam int TECH_1000FD = 5;
	localparam int TECH_WIDTH  = 6;
	localparam int SEED_WIDTH  = 11;
	localparam logic [1:0] SPEED_10   = 2'h0;
	localparam logic [1:0] SPEED_100  = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

endpackage

// File: src/psc_strap_latch.sv
`timescale 1ns/1ps
module psc_strap_latch #(
	parameter int WIDTH = psc_pkg::STRAP_WIDTH
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              hw_powerdown,
	input  wire logic [WIDTH-1:0]  strap_in,
	output logic      [WIDTH-1:0]  strap_q,
	output logic                   sampling,
	output logic                   load_defaults
);

	typedef struct packed {
		logic              sampling;
		logic [WIDTH-1:0]  straps;
	} psc_latch_t;

	psc_latch_t s_q;
	psc_latch_t s_d;
	logic       sample_now;

	assign sample_now = reset | hw_powerdown;

	// ==========================================================
	// Sampling
	always_comb
	begin
		s_d = s_q;
		s_d.sampling = sample_now;
		if (sample_now)
		begin
			s_d.straps = strap_in;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		s_q <= s_d;
	end

	assign strap_q       = s_q.straps;
	assign sampling      = s_q.sampling;
	// One pulse on the release edge; straps hold the last sample
	assign load_defaults = s_q.sampling & ~sample_now;

endmodule

// File: src/psc_core.sv
// Functional notes
// - interrupt pin open-drain, active low
// - nine interrupt sources supported
// - interrupt only when mask bit set
// - event sets its status bit
// - status read clears it
// - straps latched, become register defaults
// - sample straps at reset, powerdown
// - shared strap pins drive LEDs after reset
// - speed straps enable speed advertisement
// - duplex strap selects half or both
// - link at highest common technology
// - control bit 12 clear disables autonegotiation
// - role strap sets master preference
// - equal preferences resolved by standard
// - gigabit control bits force role
// - same forced roles block gigabit
// - crossover auto strap overrides select
// - pause strap advertises both pauses
// - station address latched from straps
`timescale 1ns/1ps
module psc_core (
	input  wire logic                              sys_clk,
	input  wire logic                              reset,
	input  wire logic                              hw_powerdown,
	input  wire logic [psc_pkg::LED_SHARED-1:0]    led_pin_in,
	output logic      [psc_pkg::LED_SHARED-1:0]    led_pin_out,
	output logic      [psc_pkg::LED_SHARED-1:0]    led_pin_oe,
	input  wire logic [psc_pkg::LED_SHARED-1:0]    led_on,
	input  wire logic                              duplex_strap,
	input  wire logic                              role_pref_strap,
	input  wire logic                              pause_strap,
	input  wire logic                              crossover_auto_strap,
	input  wire logic                              crossover_force_strap,
	input  wire logic [4:0]                        mgmt_station_addr_strap,
	output logic      [4:0]                        mgmt_station_addr,
	input  wire logic [4:0]                        reg_addr,
	input  wire logic                              reg_wr,
	input  wire logic [15:0]                       reg_wdata,
	input  wire logic                              reg_rd,
	output logic      [15:0]                       reg_rdata,
	output logic                                   reg_rvalid,
	input  wire logic [psc_pkg::NUM_IRQ-1:0]       irq_event,
	output logic                                   mgmt_interrupt_out_low_o,
	output logic                                   mgmt_interrupt_out_low_oe,
	input  wire logic                              an_complete,
	input  wire logic [psc_pkg::TECH_WIDTH-1:0]    partner_tech,
	input  wire logic                              partner_ms_manual,
	input  wire logic                              partner_ms_master,
	input  wire logic                              partner_ms_pref,
	input  wire logic [psc_pkg::SEED_WIDTH-1:0]    local_seed,
	input  wire logic [psc_pkg::SEED_WIDTH-1:0]    partner_seed,
	output logic                                   an_enable,
	output logic      [psc_pkg::TECH_WIDTH-1:0]    adv_tech,
	output logic                                   adv_pause,
	output logic                                   adv_asym_pause,
	output logic                                   adv_master_pref,
	output logic      [1:0]                        link_speed,
	output logic                                   link_full,
	output logic                                   link_master,
	output logic                                   link_permit,
	output logic                                   ms_fault,
	output logic                                   crossover_auto_en,
	output logic                                   crossover_select
);

	typedef struct packed {
		logic [15:0]                     bctl;
		logic [15:0]                     adv;
		logic [15:0]                     gctl;
		logic [15:0]                     xcfg;
		logic [psc_pkg::NUM_IRQ-1:0]     mask;
		logic [psc_pkg::NUM_IRQ-1:0]     stat;
		logic [15:0]                     rdata;
		logic                            rvalid;
		logic                            irq;
		logic [4:0]                      addr;
		logic [psc_pkg::LED_SHARED-1:0]  led_out;
		logic [1:0]                      speed;
		logic                            full;
		logic                            master;
		logic                            permit;
		logic                            fault;
	} psc_core_t;

	localparam psc_core_t CORE_RST = '{
		bctl:    psc_pkg::BASIC_CONTROL_RST,
		adv:     psc_pkg::ADVERTISE_RST,
		gctl:    psc_pkg::GIGABIT_CTRL_RST,
		xcfg:    psc_pkg::CROSSOVER_RST,
		mask:    '0,
		stat:    '0,
		rdata:   '0,
		rvalid:  1'b0,
		irq:     1'b0,
		addr:    psc_pkg::STATION_ADDR_RST,
		led_out: '0,
		speed:   psc_pkg::SPEED_1000,
		full:    1'b1,
		master:  1'b0,
		permit:  1'b0,
		fault:   1'b0
	};

	psc_core_t                          s_q;
	psc_core_t                          s_d;
	logic [psc_pkg::STRAP_WIDTH-1:0]    strap_raw;
	logic [psc_pkg::STRAP_WIDTH-1:0]    strap;
	logic                               sampling;
	logic                               load_defaults;

	assign strap_raw = {mgmt_station_addr_strap, crossover_force_strap, crossover_auto_strap,
		pause_strap, role_pref_strap, duplex_strap, led_pin_in};

	// ==========================================================
	// Strap capture
	psc_strap_latch #(
		.WIDTH         (psc_pkg::STRAP_WIDTH)
	) u_latch (
		.sys_clk       (sys_clk),
		.reset         (reset),
		.hw_powerdown  (hw_powerdown),
		.strap_in      (strap_raw),
		.strap_q       (strap),
		.sampling      (sampling),
		.load_defaults (load_defaults)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		logic [psc_pkg::NUM_IRQ-1:0]     clr;
		logic [psc_pkg::TECH_WIDTH-1:0]  lt;
		logic [psc_pkg::TECH_WIDTH-1:0]  common;
		logic                            sp1000;
		logic                            sp100;
		logic                            sp10;
		logic                            dup;
		logic                            m;
		logic                            f;
		clr    = '0;
		lt     = '0;
		common = '0;
		sp1000 = strap[psc_pkg::STRAP_SP1000];
		sp100  = strap[psc_pkg::STRAP_SP100];
		sp10   = strap[psc_pkg::STRAP_SP10];
		dup    = strap[psc_pkg::STRAP_DUPLEX];
		m      = 1'b0;
		f      = 1'b0;
		s_d    = s_q;
		s_d.rvalid = 1'b0;

		// Register writes; read-only and unmapped numbers are ignored
		if (reg_wr)
		begin
			unique case (reg_addr)
				psc_pkg::REG_BASIC_CONTROL:
					s_d.bctl = reg_wdata & psc_pkg::BC_WMASK;
				psc_pkg::REG_ADVERTISE:
					s_d.adv = (reg_wdata & psc_pkg::ADV_WMASK) | psc_pkg::ADV_SELECTOR;
				psc_pkg::REG_GIGABIT_CONTROL:
					s_d.gctl = reg_wdata & psc_pkg::GC_WMASK;
				psc_pkg::REG_CROSSOVER_CFG:
					s_d.xcfg = reg_wdata & psc_pkg::XC_WMASK;
				psc_pkg::REG_IRQ_MASK:
					s_d.mask = reg_wdata[psc_pkg::NUM_IRQ-1:0];
				default:
					;
			endcase
		end

		// Register reads; unmapped numbers read zero
		if (reg_rd)
		begin
			s_d.rvalid = 1'b1;
			unique case (reg_addr)
				psc_pkg::REG_BASIC_CONTROL:   s_d.rdata = s_q.bctl;
				psc_pkg::REG_ADVERTISE:       s_d.rdata = s_q.adv;
				psc_pkg::REG_GIGABIT_CONTROL: s_d.rdata = s_q.gctl;
				psc_pkg::REG_CROSSOVER_CFG:   s_d.rdata = s_q.xcfg;
				psc_pkg::REG_IRQ_MASK:        s_d.rdata = 16'(s_q.mask);
				psc_pkg::REG_IRQ_STATUS:      s_d.rdata = 16'(s_q.stat);
				default:                      s_d.rdata = 16'h0000;
			endcase
			clr = {psc_pkg::NUM_IRQ{reg_addr == psc_pkg::REG_IRQ_STATUS}};
		end

		s_d.stat = (s_q.stat & ~clr) | irq_event;

		if (load_defaults)
		begin
			s_d.bctl = psc_pkg::BASIC_CONTROL_RST;
			s_d.bctl[psc_pkg::BC_SPEED_MSB] = sp1000;
			s_d.bctl[psc_pkg::BC_SPEED_LSB] = ~sp1000 & sp100;
			s_d.bctl[psc_pkg::BC_DUPLEX]    = dup;
			// each speed strap advertises its speed
			s_d.adv = psc_pkg::ADV_SELECTOR;
			s_d.adv[psc_pkg::ADV_10HD]  = sp10;
			s_d.adv[psc_pkg::ADV_10FD]  = sp10 & dup;
			s_d.adv[psc_pkg::ADV_100HD] = sp100;
			s_d.adv[psc_pkg::ADV_100FD] = sp100 & dup;
			s_d.adv[psc_pkg::ADV_PAUSE]      = strap[psc_pkg::STRAP_PAUSE];
			s_d.adv[psc_pkg::ADV_ASYM_PAUSE] = strap[psc_pkg::STRAP_PAUSE];
			s_d.gctl = '0;
			s_d.gctl[psc_pkg::GC_1000HD] = sp1000;
			s_d.gctl[psc_pkg::GC_1000FD] = sp1000 & dup;
			s_d.gctl[psc_pkg::GC_PORT_PREF] = strap[psc_pkg::STRAP_ROLE];
			s_d.xcfg = '0;
			s_d.xcfg[psc_pkg::XC_AUTO]  = strap[psc_pkg::STRAP_XAUTO];
			s_d.xcfg[psc_pkg::XC_FORCE] = strap[psc_pkg::STRAP_XFORCE];
			s_d.addr = strap[psc_pkg::STRAP_ADDR_LSB +: 5];
		end

		// held while any unmasked bit pends
		s_d.irq = |(s_d.stat & s_d.mask);

		s_d.led_out = led_on ^ strap[psc_pkg::LED_SHARED-1:0];

		// Role resolution
		lt[psc_pkg::TECH_10HD]   = s_q.adv[psc_pkg::ADV_10HD];
		lt[psc_pkg::TECH_10FD]   = s_q.adv[psc_pkg::ADV_10FD];
		lt[psc_pkg::TECH_100HD]  = s_q.adv[psc_pkg::ADV_100HD];
		lt[psc_pkg::TECH_100FD]  = s_q.adv[psc_pkg::ADV_100FD];
		lt[psc_pkg::TECH_1000HD] = s_q.gctl[psc_pkg::GC_1000HD];
		lt[psc_pkg::TECH_1000FD] = s_q.gctl[psc_pkg::GC_1000FD];
		common = lt & partner_tech;
		if (s_q.gctl[psc_pkg::GC_MANUAL] && partner_ms_manual)
		begin
			// same forced roles is a fault
			m = s_q.gctl[psc_pkg::GC_MANUAL_MASTER];
			f = (s_q.gctl[psc_pkg::GC_MANUAL_MASTER] == partner_ms_master);
		end
		else if (s_q.gctl[psc_pkg::GC_MANUAL])
		begin
			m = s_q.gctl[psc_pkg::GC_MANUAL_MASTER];
		end
		else if (partner_ms_manual)
		begin
			m = ~partner_ms_master;
		end
		else if (s_q.gctl[psc_pkg::GC_PORT_PREF] != partner_ms_pref)
		begin
			m = s_q.gctl[psc_pkg::GC_PORT_PREF];
		end
		else
		begin
			m = (local_seed > partner_seed);
			f = (local_seed == partner_seed);
		end

		if (!s_q.bctl[psc_pkg::BC_AN_ENABLE])
		begin
			s_d.speed  = {s_q.bctl[psc_pkg::BC_SPEED_MSB], s_q.bctl[psc_pkg::BC_SPEED_LSB]};
			s_d.full   = s_q.bctl[psc_pkg::BC_DUPLEX];
			s_d.master = s_q.gctl[psc_pkg::GC_MANUAL_MASTER];
			s_d.fault  = 1'b0;
			s_d.permit = 1'b1;
		end
		else if (an_complete)
		begin
			if (common[psc_pkg::TECH_1000FD] || common[psc_pkg::TECH_1000HD])
			begin
				s_d.speed = psc_pkg::SPEED_1000;
				s_d.full  = common[psc_pkg::TECH_1000FD];
			end
			else if (common[psc_pkg::TECH_100FD] || common[psc_pkg::TECH_100HD])
			begin
				s_d.speed = psc_pkg::SPEED_100;
				s_d.full  = common[psc_pkg::TECH_100FD];
			end
			else
			begin
				s_d.speed = psc_pkg::SPEED_10;
				s_d.full  = common[psc_pkg::TECH_10FD];
			end
			s_d.master = m;
			s_d.fault  = f;
			// no gigabit link on role fault
			s_d.permit = (|common) && !(f && s_d.speed == psc_pkg::SPEED_1000);
		end
		else
		begin
			s_d.permit = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		s_q <= reset ? CORE_RST : s_d;
	end

	// ==========================================================
	// Outputs
	// pin only ever pulled low
	assign mgmt_interrupt_out_low_o  = 1'b0;
	assign mgmt_interrupt_out_low_oe = s_q.irq;
	// LEDs stay undriven while straps are being sampled
	assign led_pin_out       = s_q.led_out;
	assign led_pin_oe        = {psc_pkg::LED_SHARED{~sampling}};
	assign mgmt_station_addr = s_q.addr;
	assign reg_rdata         = s_q.rdata;
	assign reg_rvalid        = s_q.rvalid;
	assign an_enable         = s_q.bctl[psc_pkg::BC_AN_ENABLE];
	assign adv_tech          = {s_q.gctl[psc_pkg::GC_1000FD], s_q.gctl[psc_pkg::GC_1000HD],
		s_q.adv[psc_pkg::ADV_100FD], s_q.adv[psc_pkg::ADV_100HD],
		s_q.adv[psc_pkg::ADV_10FD], s_q.adv[psc_pkg::ADV_10HD]};
	assign adv_pause         = s_q.adv[psc_pkg::ADV_PAUSE];
	assign adv_asym_pause    = s_q.adv[psc_pkg::ADV_ASYM_PAUSE];
	assign adv_master_pref   = s_q.gctl[psc_pkg::GC_PORT_PREF];
	assign link_speed        = s_q.speed;
	assign link_full         = s_q.full;
	assign link_master       = s_q.master;
	assign link_permit       = s_q.permit;
	assign ms_fault          = s_q.fault;
	assign crossover_auto_en = s_q.xcfg[psc_pkg::XC_AUTO];
	assign crossover_select  = s_q.xcfg[psc_pkg::XC_AUTO] ? 1'b0 : s_q.xcfg[psc_pkg::XC_FORCE];

endmodule

// File: tb/psc_core_properties.sv
`timescale 1ns/1ps
module psc_core_properties (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        hw_powerdown,
	input wire logic [2:0]  led_pin_oe,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [8:0]  irq_event,
	input wire logic        mgmt_interrupt_out_low_o,
	input wire logic        mgmt_interrupt_out_low_oe,
	input wire logic        an_enable,
	input wire logic        an_complete,
	input wire logic        link_permit,
	input wire logic        ms_fault,
	input wire logic [4:0]  mgmt_station_addr,
	input wire logic        crossover_auto_en,
	input wire logic        crossover_select
);
	// ==========================================================
	// Shadow of mask and pending status; set wins over read-clear
	logic [8:0] mask_q;
	logic [8:0] stat_q;
	always_ff @(posedge sys_clk)
	begin
		mask_q <= reset ? 9'h000 : (reg_wr && reg_addr == psc_pkg::REG_IRQ_MASK) ?
			reg_wdata[8:0] : mask_q;
		stat_q <= reset ? 9'h000 : irq_event |
			((reg_rd && reg_addr == psc_pkg::REG_IRQ_STATUS) ? 9'h000 : stat_q);
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_irq_open_drain: assert property (mgmt_interrupt_out_low_o == 1'b0)
		else $error("interrupt pin drives a high level");
	chk_irq_follows_mask: assert property (mgmt_interrupt_out_low_oe == |(stat_q & mask_q))
		else $error("interrupt enable disagrees with pending unmasked status");
	chk_status_read: assert property ((reg_rd && reg_addr == psc_pkg::REG_IRQ_STATUS) |=>
		(reg_rvalid && reg_rdata == {7'h00, $past(stat_q)}))
		else $error("status read returned wrong bits");
	chk_led_release: assert property (hw_powerdown |=> led_pin_oe == 3'h0)
		else $error("shared pins driven during powerdown");
	chk_led_drive: assert property ((!hw_powerdown)[*2] |-> led_pin_oe == 3'h7)
		else $error("shared pins not driven after release");
	chk_addr_hold: assert property ((!hw_powerdown)[*3] |-> $stable(mgmt_station_addr))
		else $error("station address changed outside sampling");
	chk_forced_link: assert property ((!an_enable)[*2] |-> (link_permit && !ms_fault))
		else $error("forced mode did not permit link");
	chk_an_wait: assert property ((an_enable && !an_complete)[*2] |-> !link_permit)
		else $error("link permitted before negotiation completed");
	chk_cross_auto: assert property (crossover_auto_en |-> !crossover_select)
		else $error("crossover select set while automatic");
endmodule

bind psc_core psc_core_properties psc_core_properties_inst (.sys_clk, .reset, .hw_powerdown,
	.led_pin_oe, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .irq_event,
	.mgmt_interrupt_out_low_o, .mgmt_interrupt_out_low_oe, .an_enable, .an_complete,
	.link_permit, .ms_fault, .mgmt_station_addr, .crossover_auto_en, .crossover_select);

// File: tb/psc_host_model.sv
`timescale 1ns/1ps
module psc_host_model (
	input  wire logic        sys_clk,
	input  wire logic        irq_oe,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output logic      [4:0]  reg_addr,
	output logic             reg_wr,
	output logic      [15:0] reg_wdata,
	output logic             reg_rd,
	output logic             irq_line,
	output logic             rd_ok
);
	// Shared line with pull-up; any device pulls it low
	assign irq_line = irq_oe ? 1'b0 : 1'b1;
	initial
	begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
		rd_ok = 1'b0;
	end
	// Released address and data show the inverse, never a stale match
	task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		rd_ok = reg_rvalid;
		d = reg_rdata;
	endtask
	task automatic service_irq(output logic [15:0] d);
		d = 16'h0000;
		if (irq_line === 1'b0)
			read_reg(psc_pkg::REG_IRQ_STATUS, d);
	endtask
endmodule

// File: tb/psc_core_tb.sv
`timescale 1ns/1ps
module psc_core_tb;
	logic sys_clk = 1'b0, reset = 1'b1, hw_powerdown = 1'b0, irq_line, rd_ok;
	logic [2:0] led_strap = 3'h7, led_on = 3'h1, led_pin_in, led_pin_out, led_pin_oe;
	logic duplex_s = 1'b1, role_s = 1'b0, pause_s = 1'b0, xauto_s = 1'b1, xforce_s = 1'b0;
	logic [4:0] addr_s = 5'h01, station, reg_addr;
	logic reg_wr, reg_rd, reg_rvalid, irq_o, irq_oe, an_complete = 1'b0;
	logic [15:0] reg_wdata, reg_rdata;
	logic [8:0] irq_event = 9'h000;
	logic [5:0] partner_tech = 6'h00, adv_tech;
	logic p_manual = 1'b0, p_master = 1'b0, p_pref = 1'b0;
	logic [10:0] local_seed = 11'h100, partner_seed = 11'h050;
	logic an_enable, adv_pause, adv_asym, adv_master, link_full, link_master, link_permit;
	logic ms_fault, x_auto, x_sel;
	logic [1:0] link_speed;
	int errors = 0, n_compared = 0;
	// Shared pin level: strap pull until the core drives it
	assign led_pin_in = (led_pin_oe & led_pin_out) | (~led_pin_oe & led_strap);

	psc_core psc_core_inst (.sys_clk, .reset, .hw_powerdown, .led_pin_in, .led_pin_out,
		.led_pin_oe, .led_on, .duplex_strap(duplex_s), .role_pref_strap(role_s),
		.pause_strap(pause_s), .crossover_auto_strap(xauto_s), .crossover_force_strap(xforce_s),
		.mgmt_station_addr_strap(addr_s), .mgmt_station_addr(station), .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .irq_event,
		.mgmt_interrupt_out_low_o(irq_o), .mgmt_interrupt_out_low_oe(irq_oe), .an_complete,
		.partner_tech, .partner_ms_manual(p_manual), .partner_ms_master(p_master),
		.partner_ms_pref(p_pref), .local_seed, .partner_seed, .an_enable, .adv_tech,
		.adv_pause, .adv_asym_pause(adv_asym), .adv_master_pref(adv_master), .link_speed,
		.link_full, .link_master, .link_permit, .ms_fault, .crossover_auto_en(x_auto),
		.crossover_select(x_sel));
	psc_host_model psc_host_model_inst (.sys_clk, .irq_oe, .reg_rdata, .reg_rvalid, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rd, .irq_line, .rd_ok);

	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			errors++;
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		psc_host_model_inst.read_reg(a, d);
		check("read valid", 16'h0001, 16'(rd_ok));
		check("read data", exp, d);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		rd_chk(psc_pkg::REG_BASIC_CONTROL, psc_pkg::BASIC_CONTROL_RST);
		rd_chk(psc_pkg::REG_ADVERTISE, psc_pkg::ADVERTISE_RST);
		rd_chk(psc_pkg::REG_GIGABIT_CONTROL, psc_pkg::GIGABIT_CTRL_RST);
		rd_chk(psc_pkg::REG_CROSSOVER_CFG, psc_pkg::CROSSOVER_RST);
		rd_chk(psc_pkg::REG_IRQ_MASK, 16'h0000);
		rd_chk(5'h1F, 16'h0000);
		check("adv tech", 16'h003F, 16'(adv_tech));
		check("pause", 16'h0000, {14'h0000, adv_pause, adv_asym});
		check("role", 16'h0000, 16'(adv_master));
		check("station", 16'(psc_pkg::STATION_ADDR_RST), 16'(station));
		check("led out", 16'(led_on ^ 3'h7), 16'(led_pin_out));
		$display("test defaults done");
	endtask
	task automatic t_straps();
		led_strap <= 3'h2;
		duplex_s <= 1'b0;
		role_s <= 1'b1;
		pause_s <= 1'b1;
		xauto_s <= 1'b0;
		xforce_s <= 1'b1;
		addr_s <= 5'h0A;
		hw_powerdown <= 1'b1;
		wait_cyc(3);
		hw_powerdown <= 1'b0;
		wait_cyc(3);
		check("adv tech", 16'h0004, 16'(adv_tech));
		check("pause", 16'h0003, {14'h0000, adv_pause, adv_asym});
		check("role", 16'h0001, 16'(adv_master));
		check("cross", 16'h0001, {14'h0000, x_auto, x_sel});
		check("station", 16'h000A, 16'(station));
		check("led out", 16'(led_on ^ 3'h2), 16'(led_pin_out));
		rd_chk(psc_pkg::REG_ADVERTISE, 16'h0C81);
		psc_host_model_inst.write_reg(psc_pkg::REG_CROSSOVER_CFG, 16'h0003);
		wait_cyc(1);
		check("cross auto", 16'h0002, {14'h0000, x_auto, x_sel});
		led_strap <= 3'h7;
		duplex_s <= 1'b1;
		role_s <= 1'b0;
		pause_s <= 1'b0;
		xauto_s <= 1'b1;
		xforce_s <= 1'b0;
		addr_s <= 5'h01;
		reset <= 1'b1;
		wait_cyc(16);
		reset <= 1'b0;
		wait_cyc(2);
		rd_chk(psc_pkg::REG_ADVERTISE, psc_pkg::ADVERTISE_RST);
		check("station", 16'h0001, 16'(station));
		$display("test straps done");
	endtask
	task automatic t_irq();
		logic [15:0] b, d;
		for (int n = 0; n < psc_pkg::NUM_IRQ; n++)
		begin
			b = 16'h0001 << n;
			psc_host_model_inst.write_reg(psc_pkg::REG_IRQ_MASK, b);
			@(posedge sys_clk);
			irq_event <= b[8:0];
			@(posedge sys_clk);
			irq_event <= 9'h000;
			wait_cyc(3);
			check("irq held", 16'h0000, 16'(irq_line));
			psc_host_model_inst.service_irq(d);
			check("irq status", b, d);
			check("irq freed", 16'h0001, 16'(irq_line));
		end
		psc_host_model_inst.write_reg(psc_pkg::REG_IRQ_MASK, 16'h01FE);
		psc_host_model_inst.write_reg(psc_pkg::REG_IRQ_STATUS, 16'h01FF);
		@(posedge sys_clk);
		irq_event <= 9'h001;
		@(posedge sys_clk);
		irq_event <= 9'h000;
		wait_cyc(1);
		check("irq masked", 16'h0001, 16'(irq_line));
		irq_event <= 9'h002;
		rd_chk(psc_pkg::REG_IRQ_STATUS, 16'h0003);
		irq_event <= 9'h000;
		rd_chk(psc_pkg::REG_IRQ_STATUS, 16'h0002);
		rd_chk(psc_pkg::REG_IRQ_STATUS, 16'h0000);
		$display("test interrupt done");
	endtask
	task automatic t_force();
		psc_host_model_inst.write_reg(psc_pkg::REG_BASIC_CONTROL, 16'h2100);
		wait_cyc(2);
		check("forced", 16'h000B, {11'h000, an_enable, link_permit, link_speed, link_full});
		psc_host_model_inst.write_reg(psc_pkg::REG_BASIC_CONTROL, 16'h0040);
		wait_cyc(2);
		check("forced", 16'h000C, {11'h000, an_enable, link_permit, link_speed, link_full});
		psc_host_model_inst.write_reg(psc_pkg::REG_BASIC_CONTROL, psc_pkg::BASIC_CONTROL_RST);
		$display("test forced done");
	endtask
	task automatic t_resolve();
		an_complete <= 1'b1;
		partner_tech <= 6'h0F;
		wait_cyc(3);
		check("common", 16'h000B, {12'h000, link_permit, link_speed, link_full});
		partner_tech <= 6'h3F;
		wait_cyc(3);
		check("gigabit", 16'h001D, {11'h000, link_master, link_permit, link_speed, link_full});
		psc_host_model_inst.write_reg(psc_pkg::REG_GIGABIT_CONTROL, 16'h1B00);
		p_manual <= 1'b1;
		p_master <= 1'b1;
		wait_cyc(3);
		check("same role", 16'h0002, {14'h0000, ms_fault, link_permit});
		p_master <= 1'b0;
		wait_cyc(3);
		check("forced role", 16'h0005, {13'h0000, link_master, ms_fault, link_permit});
		psc_host_model_inst.write_reg(psc_pkg::REG_GIGABIT_CONTROL, psc_pkg::GIGABIT_CTRL_RST);
		p_manual <= 1'b0;
		an_complete <= 1'b0;
		wait_cyc(2);
		$display("test resolve done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		wait_cyc(16);
		reset <= 1'b0;
		wait_cyc(2);
		t_defaults();
		t_straps();
		t_irq();
		t_force();
		t_resolve();
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		test_done();
	end
endmodule
